// ==== src/lpcw_pkg.sv ====
// Constants and helpers for the low-pin-count flash write target.
// Assumes a 4-bit multiplexed bus sampled on the rising edge of clk.
package lpcw_pkg;

    localparam logic [3:0] LPCW_START_CODE   = 4'h0;
    localparam logic [2:0] LPCW_MEM_WRITE    = 3'h3;   // Bits 3:1 of the type field
    localparam logic [3:0] LPCW_TURN_NIBBLE  = 4'hf;
    localparam logic [3:0] LPCW_READY_NIBBLE = 4'h0;
    localparam logic [3:0] LPCW_WAIT_NIBBLE  = 4'h5;   // Not used: writes insert no waits
    localparam int         LPCW_ADDR_NIBBLES = 8;
    localparam logic [2:0] LPCW_LAST_NIBBLE  = 3'h7;
    localparam logic [2:0] LPCW_NIBBLE_ZERO  = 3'h0;
    localparam logic [2:0] LPCW_NIBBLE_ONE   = 3'h1;
    localparam int         LPCW_FLASH_BIT    = 23;
    localparam int         LPCW_ID_HI        = 22;
    localparam int         LPCW_ID_LO        = 20;
    localparam int         LPCW_SECT_HI      = 19;
    localparam int         LPCW_SECT_LO      = 16;
    localparam logic [3:0] LPCW_TOP_SECTOR   = 4'hf;
    localparam int         LPCW_SECTORS      = 16;

    typedef enum logic [3:0] {
        LPCW_IDLE,
        LPCW_CYCTYPE,
        LPCW_ADDR,
        LPCW_DATA_LO,
        LPCW_DATA_HI,
        LPCW_HOST_TAR,
        LPCW_OWN_TAR,
        LPCW_SYNC,
        LPCW_BACK_TAR
    } lpcw_state_t;

    // Sector index of a flash address
    function automatic logic [3:0] lpcw_sector(input logic [31:0] addr);
        return addr[LPCW_SECT_HI:LPCW_SECT_LO];
    endfunction

    // Protection decision for one sector
    function automatic logic lpcw_blocked(input logic [3:0]  sector,
                                          input logic        top_n,
                                          input logic        gen_n,
                                          input logic [15:0] locks);
        logic pin_block;
        pin_block = (sector == LPCW_TOP_SECTOR) ? !top_n : !gen_n;
        return pin_block | locks[sector];
    endfunction

endpackage

// ==== src/lpcw_cyc_if.sv ====
// Carries the assembled cycle address and its decode between the bus
// sequencer and the address decoder.
`timescale 1ns/1ps
interface lpcw_cyc_if;
    logic [31:0] addr;
    logic [2:0]  id_strap;
    logic        to_flash;
    logic        id_match;
    logic [3:0]  sector;

    modport seq
    (
        output addr,
        output id_strap,
        input  to_flash,
        input  id_match,
        input  sector
    );
    modport dec
    (
        input  addr,
        input  id_strap,
        output to_flash,
        output id_match,
        output sector
    );
endinterface

// ==== src/lpcw_addr_dec.sv ====
// Address decoder: flash or register space, device select, sector.
// Assumes the address on the interface is stable while it is read.
`timescale 1ns/1ps
module lpcw_addr_dec
    import lpcw_pkg::*;
(
    lpcw_cyc_if.dec cyc    // Address in, decode out
);

    always_comb
    begin
        cyc.to_flash = cyc.addr[LPCW_FLASH_BIT];                           // RULE_20
        cyc.id_match = (cyc.addr[LPCW_ID_HI:LPCW_ID_LO] == cyc.id_strap);  // RULE_20
        cyc.sector   = lpcw_sector(cyc.addr);                              // RULE_19
    end

endmodule

// ==== src/lpcw_guard.sv ====
// Hardware write protection: samples the guard pins and write-lock bits
// when an internal program or erase starts and holds them until it ends.
// Assumes op_start pulses once per operation and op_active spans it,
// suspend included.
`timescale 1ns/1ps
module lpcw_guard
    import lpcw_pkg::*;
(
    input  wire logic        clk,                 // System clock
    input  wire logic        reset_n,             // Synchronous reset
    input  wire logic        op_start,            // Operation begins
    input  wire logic [3:0]  op_sector,           // Target sector
    input  wire logic        op_active,           // Operation or suspend
    input  wire logic        top_sector_guard_n,  // Top sector lock pin
    input  wire logic        write_guard_n,       // Other sectors lock pin
    input  wire logic [15:0] write_lock,          // Register write-lock bits
    output logic             op_permit,           // Operation may proceed
    output logic             op_refused           // Operation blocked
);

    logic        held;
    logic        next_held;
    logic        next_permit;
    logic        next_refused;

    always_comb
    begin
        next_held    = held;
        next_permit  = op_permit;
        next_refused = op_refused;
        if (op_start)
        begin
            next_held    = 1'b1;
            next_permit  = !lpcw_blocked(op_sector, top_sector_guard_n,
                                         write_guard_n, write_lock);  // RULE_14 RULE_15 RULE_16 RULE_18 RULE_21
            next_refused = !next_permit;
        end
        else if (held && !op_active)
        begin
            // Decision released only once the operation completes
            next_held    = 1'b0;                                      // RULE_17
            next_permit  = 1'b0;
            next_refused = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            held       <= 1'b0;
            op_permit  <= 1'b0;
            op_refused <= 1'b0;
        end
        else
        begin
            held       <= next_held;
            op_permit  <= next_permit;
            op_refused <= next_refused;
        end
    end

endmodule

// ==== src/lpcw_target.sv ====
// Target-side memory write cycle logic of a low-pin-count flash, with
// hardware write protection of its sixteen sectors.
// Assumes a host drives the frame and nibble lines synchronous to clk
// and a flash core that consumes write strobes and runs operations.
//
// Overview of operation
// (RULE_01) Host sends data low nibble then high
// (RULE_02) Cycle starts on last start code clock
// (RULE_03) Type 011x is a memory write
// (RULE_04) Address assembled from eight nibbles, MSN first
// (RULE_05) Data byte captured on clocks eleven, twelve
// (RULE_06) Host drives ones then releases, clock thirteen
// (RULE_07) Device takes the bus during clock fourteen
// (RULE_08) Ready handshake on clock fifteen, no waits
// (RULE_09) Drive ones clock sixteen, float clock seventeen
// (RULE_10) Outputs float whenever not addressed
// (RULE_11) Frame low mid-cycle aborts to idle, floats
// (RULE_12) Abort never cancels running internal operation
// (RULE_13) No internal operation before last data nibble
// (RULE_14) Top guard pin low blocks top sector
// (RULE_15) Write guard pin low blocks other sectors
// (RULE_16) Guard pins sampled when operation begins
// (RULE_17) Pin change during suspend applies after completion
// (RULE_18) Pins block regardless of register lock bit
// (RULE_19) Sector from address bits nineteen to sixteen
// (RULE_20) Bit 23 selects flash, 22:20 match straps
// (RULE_21) Register write-lock bit also blocks its sector
`timescale 1ns/1ps
module lpcw_target
    import lpcw_pkg::*;
(
    input  wire logic        clk,                 // 50 MHz system clock
    input  wire logic        reset_n,             // Synchronous reset
    input  wire logic        frame_n,             // Cycle framing from host
    input  wire logic [3:0]  lad_in,              // Bus nibble in
    output logic      [3:0]  lad_out,             // Bus nibble out
    output logic             lad_oe,              // Bus nibble drive enable
    input  wire logic [2:0]  id_strap,            // Device select straps
    output logic             wr_strobe,           // Write byte accepted
    output logic      [31:0] wr_addr,             // Address of that byte
    output logic      [7:0]  wr_data,             // Data or command byte
    output logic             wr_to_flash,         // Byte is for flash array
    output logic             cycle_abort,         // Cycle cut by frame
    input  wire logic        op_start,            // Core starts an operation
    input  wire logic [3:0]  op_sector,           // Sector of that operation
    input  wire logic        op_active,           // Operation running or held
    input  wire logic        top_sector_guard_n,  // Top sector lock pin
    input  wire logic        write_guard_n,       // Other sectors lock pin
    input  wire logic [15:0] write_lock,          // Register write-lock bits
    output logic             op_permit,           // Operation allowed
    output logic             op_refused           // Operation blocked
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    lpcw_cyc_if cyc ();

    lpcw_addr_dec u_dec
    (
        .cyc (cyc.dec)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus sequencer state

    lpcw_state_t state;
    lpcw_state_t next_state;
    logic [2:0]  nib_cnt;
    logic [2:0]  next_nib_cnt;
    logic [31:0] addr;
    logic [31:0] next_addr;
    logic [3:0]  data_lo;
    logic [3:0]  next_data_lo;
    logic        selected;
    logic        next_selected;
    logic [3:0]  next_lad_out;
    logic        next_lad_oe;
    logic        next_wr_strobe;
    logic [31:0] next_wr_addr;
    logic [7:0]  next_wr_data;
    logic        next_wr_to_flash;
    logic        next_cycle_abort;

    assign cyc.addr     = addr;
    assign cyc.id_strap = id_strap;

    always_comb
    begin
        next_state       = state;
        next_nib_cnt     = nib_cnt;
        next_addr        = addr;
        next_data_lo     = data_lo;
        next_selected    = selected;
        next_lad_out     = lad_out;
        next_lad_oe      = lad_oe;
        next_wr_strobe   = 1'b0;
        next_wr_addr     = wr_addr;
        next_wr_data     = wr_data;
        next_wr_to_flash = wr_to_flash;
        next_cycle_abort = 1'b0;

        if (!frame_n)
        begin
            // Frame low wins everywhere: release the bus and restart
            next_lad_oe      = 1'b0;                                   // RULE_11
            next_lad_out     = LPCW_TURN_NIBBLE;
            next_selected    = 1'b0;
            next_cycle_abort = (state != LPCW_IDLE) &&
                               (state != LPCW_CYCTYPE);                // RULE_11
            if (lad_in == LPCW_START_CODE)
                next_state = LPCW_CYCTYPE;                             // RULE_02
            else
                next_state = LPCW_IDLE;                                // RULE_11
        end
        else
        begin
            unique case (state)
                LPCW_IDLE:
                begin
                    next_lad_oe = 1'b0;                                // RULE_10
                end
                LPCW_CYCTYPE:
                begin
                    // Bit 0 of the type field is ignored
                    next_nib_cnt = LPCW_NIBBLE_ZERO;
                    if (lad_in[3:1] == LPCW_MEM_WRITE)
                        next_state = LPCW_ADDR;                        // RULE_03
                    else
                        next_state = LPCW_IDLE;
                end
                LPCW_ADDR:
                begin
                    next_addr    = {addr[27:0], lad_in};               // RULE_04
                    next_nib_cnt = nib_cnt + LPCW_NIBBLE_ONE;
                    if (nib_cnt == LPCW_LAST_NIBBLE)
                        next_state = LPCW_DATA_LO;
                end
                LPCW_DATA_LO:
                begin
                    next_data_lo  = lad_in;                            // RULE_01 RULE_05
                    next_selected = cyc.id_match;                      // RULE_20
                    next_state    = LPCW_DATA_HI;
                end
                LPCW_DATA_HI:
                begin
                    // Launch only once the last nibble is in
                    if (selected)
                    begin
                        next_wr_strobe   = 1'b1;                       // RULE_13
                        next_wr_addr     = addr;
                        next_wr_data     = {lad_in, data_lo};          // RULE_01 RULE_05
                        next_wr_to_flash = cyc.to_flash;               // RULE_20
                        next_state       = LPCW_HOST_TAR;
                    end
                    else
                        next_state = LPCW_IDLE;                        // RULE_10
                end
                LPCW_HOST_TAR:
                begin
                    // Host drives ones this clock; take the bus for the next
                    next_lad_oe  = 1'b1;                               // RULE_06 RULE_07
                    next_lad_out = LPCW_TURN_NIBBLE;
                    next_state   = LPCW_OWN_TAR;
                end
                LPCW_OWN_TAR:
                begin
                    next_lad_out = LPCW_READY_NIBBLE;                  // RULE_08
                    next_state   = LPCW_SYNC;
                end
                LPCW_SYNC:
                begin
                    next_lad_out = LPCW_TURN_NIBBLE;                   // RULE_09
                    next_state   = LPCW_BACK_TAR;
                end
                LPCW_BACK_TAR:
                begin
                    next_lad_oe   = 1'b0;                              // RULE_09
                    next_selected = 1'b0;
                    next_state    = LPCW_IDLE;
                end
                default:
                begin
                    next_lad_oe = 1'b0;
                    next_state  = LPCW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state       <= LPCW_IDLE;
            nib_cnt     <= LPCW_NIBBLE_ZERO;
            addr        <= 32'h0000_0000;
            data_lo     <= 4'h0;
            selected    <= 1'b0;
            lad_out     <= LPCW_TURN_NIBBLE;
            lad_oe      <= 1'b0;
            wr_strobe   <= 1'b0;
            wr_addr     <= 32'h0000_0000;
            wr_data     <= 8'h00;
            wr_to_flash <= 1'b0;
            cycle_abort <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            nib_cnt     <= next_nib_cnt;
            addr        <= next_addr;
            data_lo     <= next_data_lo;
            selected    <= next_selected;
            lad_out     <= next_lad_out;
            lad_oe      <= next_lad_oe;
            wr_strobe   <= next_wr_strobe;
            wr_addr     <= next_wr_addr;
            wr_data     <= next_wr_data;
            wr_to_flash <= next_wr_to_flash;
            cycle_abort <= next_cycle_abort;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hardware protection; independent of the bus sequencer, so an abort
    // leaves a running operation and its decision untouched

    lpcw_guard u_guard                                                 // RULE_12
    (
        .clk                (clk),
        .reset_n            (reset_n),
        .op_start           (op_start),
        .op_sector          (op_sector),
        .op_active          (op_active),
        .top_sector_guard_n (top_sector_guard_n),
        .write_guard_n      (write_guard_n),
        .write_lock         (write_lock),
        .op_permit          (op_permit),
        .op_refused         (op_refused)
    );

endmodule

// ==== tb/lpcw_target_assertions.sv ====
// Port-level assertions for the flash write target.
// Assumes one clock domain and binding onto lpcw_target.
`timescale 1ns/1ps
module lpcw_target_chk
    import lpcw_pkg::*;
(
    input wire logic        clk,                // Clock
    input wire logic        reset_n,            // Sync reset
    input wire logic        frame_n,            // Frame
    input wire logic [3:0]  lad_out,            // Driven nibble
    input wire logic        lad_oe,             // Drive enable
    input wire logic        wr_strobe,          // Byte accepted
    input wire logic        cycle_abort,        // Abort pulse
    input wire logic        op_start,           // Operation begins
    input wire logic [3:0]  op_sector,          // Its sector
    input wire logic        op_active,          // Operation running
    input wire logic        top_sector_guard_n, // Top lock pin
    input wire logic        write_guard_n,      // Other lock pin
    input wire logic [15:0] write_lock,         // Lock bits
    input wire logic        op_permit,          // Allowed
    input wire logic        op_refused          // Blocked
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence give_back;
        lad_oe && lad_out == LPCW_TURN_NIBBLE ##1 !lad_oe;
    endsequence
    sequence no_start_2;
        !op_active && !op_start ##1 !op_start;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    take_bus_a: assert property (wr_strobe && frame_n |=> $rose(lad_oe)
        && lad_out == LPCW_TURN_NIBBLE) else $error("bus not taken after write byte");
    ready_sync_a: assert property ($rose(lad_oe) && frame_n |=> lad_oe
        && lad_out == LPCW_READY_NIBBLE) else $error("ready nibble missing");
    hand_back_a: assert property (lad_oe && lad_out == LPCW_READY_NIBBLE && frame_n
        |=> give_back) else $error("turnaround back to host wrong");
    drive_cause_a: assert property ($rose(lad_oe) |-> $past(wr_strobe))
        else $error("bus driven without accepted write");
    abort_release_a: assert property (!frame_n |=> !lad_oe)
        else $error("bus still driven after frame low");
    abort_cause_a: assert property (cycle_abort |-> $past(frame_n) == 1'b0)
        else $error("abort pulse without frame low");
    strobe_pulse_a: assert property (wr_strobe |=> !wr_strobe)
        else $error("write strobe longer than one cycle");
    top_block_a: assert property (op_start && op_sector == LPCW_TOP_SECTOR
        && !top_sector_guard_n |=> op_refused && !op_permit) else $error("top sector not blocked");
    other_block_a: assert property (op_start && op_sector != LPCW_TOP_SECTOR
        && !write_guard_n |=> op_refused && !op_permit) else $error("sector not blocked");
    lock_block_a: assert property (op_start && write_lock[op_sector]
        |=> op_refused) else $error("locked sector not blocked");
    open_sector_a: assert property (op_start && !write_lock[op_sector] && (op_sector ==
        LPCW_TOP_SECTOR ? top_sector_guard_n : write_guard_n) |=> op_permit && !op_refused)
        else $error("open sector refused");
    guard_hold_a: assert property (op_active && !op_start |=> $stable(op_permit)
        && $stable(op_refused)) else $error("permission changed mid operation");
    guard_clear_a: assert property (no_start_2 |=> !op_permit && !op_refused)
        else $error("permission not cleared");
endmodule

bind lpcw_target lpcw_target_chk chk (.*);

// ==== tb/lpcw_host.sv ====
// Host controller model: frames write cycles and records the answers.
// Assumes the bench resolves the nibble wire with pull-ups.
`timescale 1ns/1ps
module lpcw_host
    import lpcw_pkg::*;
(
    input  wire logic       clk,       // Bus clock
    input  wire logic [3:0] lad,       // Resolved nibble wire
    input  wire logic       lad_oe,    // Device drives
    input  wire logic       wr_strobe, // Byte accepted
    output logic            frame_n,   // Cycle frame
    output logic            host_en,   // Host drives wire
    output logic      [3:0] host_val   // Host nibble
);
    logic [17:0] oe_seen;
    logic [17:0] stb_seen;
    logic [3:0]  sync_seen;
    initial
    begin
        frame_n  = 1'b1;
        host_en  = 1'b0;
        host_val = 4'hf;
    end
    task automatic field(input logic fr, input logic en, input logic [3:0] v);
        @(negedge clk);
        frame_n  = fr;
        host_en  = en;
        host_val = v;
    endtask
    // Record index k is the device's state during clock k
    task automatic write(input logic [31:0] a, input logic [7:0] d, input logic [3:0] t,
                         input int starts, input int abort_at);
        oe_seen   = '0;
        stb_seen  = '0;
        sync_seen = 4'hf;
        repeat (starts) field(1'b0, 1'b1, LPCW_START_CODE);
        for (int k = 2; k < 18; k++)
        begin
            if (k == abort_at) field(1'b0, k <= 13, 4'hf);
            else if (k == 2) field(1'b1, 1'b1, t);
            else if (k <= 10) field(1'b1, 1'b1, a[4 * (10 - k) +: 4]);
            else if (k <= 12) field(1'b1, 1'b1, k == 11 ? d[3:0] : d[7:4]);
            else field(1'b1, k == 13, 4'hf);
            oe_seen[k]  = lad_oe;
            stb_seen[k] = wr_strobe;
            if (k == 15) sync_seen = lad;
        end
    endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the flash write target.
// Assumes pull-ups hold the nibble wire high when undriven.
`timescale 1ns/1ps
module testbench;
    import lpcw_pkg::*;
    typedef struct {logic [31:0] a; logic [7:0] d; logic [3:0] t; logic sel;} lpcw_row_t;
    localparam logic [17:0] OE_ON  = 18'h1c000;
    localparam logic [17:0] STB_ON = 18'h02000;
    logic        clk, reset_n, frame_n, host_en, lad_oe, wr_strobe, wr_to_flash, cycle_abort;
    logic        op_start, op_active, top_sector_guard_n, write_guard_n, op_permit, op_refused;
    logic        blk;
    logic [3:0]  lad_in, lad_out, host_val, op_sector;
    logic [2:0]  id_strap;
    logic [7:0]  wr_data;
    logic [15:0] write_lock;
    logic [31:0] wr_addr;
    int          errors = 0, cmp_count = 0, aborts = 0;
    lpcw_row_t   rows[5] = '{'{32'hffbf0012, 8'ha5, 4'h6, 1'b1}, '{32'hff3e5007, 8'h3c, 4'h7, 1'b1},
                         '{32'hffcf0000, 8'h11, 4'h6, 1'b0}, '{32'hffbf0000, 8'h22, 4'h4, 1'b0},
                         '{32'hffbf0000, 8'h33, 4'he, 1'b0}};
    assign lad_in = lad_oe ? lad_out : (host_en ? host_val : 4'hf);
    lpcw_target uut (.clk(clk), .reset_n(reset_n), .frame_n(frame_n), .lad_in(lad_in),
        .lad_out(lad_out), .lad_oe(lad_oe), .id_strap(id_strap), .wr_strobe(wr_strobe),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_to_flash(wr_to_flash),
        .cycle_abort(cycle_abort), .op_start(op_start), .op_sector(op_sector),
        .op_active(op_active), .top_sector_guard_n(top_sector_guard_n),
        .write_guard_n(write_guard_n), .write_lock(write_lock), .op_permit(op_permit),
        .op_refused(op_refused));
    lpcw_host host (.clk(clk), .lad(lad_in), .lad_oe(lad_oe), .wr_strobe(wr_strobe),
        .frame_n(frame_n), .host_en(host_en), .host_val(host_val));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) if (cycle_abort === 1'b1) aborts++;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        reset_n = 1'b0; op_start = 1'b0; op_active = 1'b0; op_sector = 4'h0; id_strap = 3'h3;
        top_sector_guard_n = 1'b1; write_guard_n = 1'b1; write_lock = 16'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        check({lad_oe, lad_out, op_permit, op_refused}, 7'h3c);
        foreach (rows[i])
        begin
            host.write(rows[i].a, rows[i].d, rows[i].t, 1, 0);
            check(host.oe_seen, rows[i].sel ? OE_ON : 18'h0);
            check(host.stb_seen, rows[i].sel ? STB_ON : 18'h0);
            if (rows[i].sel)
            begin
                check(host.sync_seen, LPCW_READY_NIBBLE);
                check(wr_addr, rows[i].a);
                check(wr_data, rows[i].d);
                check(wr_to_flash, rows[i].a[23]);
            end
        end
        host.write(32'hffbf1234, 8'h5a, 4'h6, 2, 0);
        check({host.oe_seen, wr_data}, {OE_ON, 8'h5a});
        host.write(32'hffbf0000, 8'h77, 4'h6, 1, 12);
        check({host.stb_seen | host.oe_seen, wr_data}, 26'h5a);
        check(aborts, 1);
        @(negedge clk);
        op_sector = 4'h2; op_start = 1'b1; op_active = 1'b1;
        @(negedge clk);
        op_start = 1'b0;
        host.write(32'hff3e0000, 8'h99, 4'h6, 1, 15);
        check({host.oe_seen, aborts[1:0]}, {18'h0c000, 2'h2});
        check({op_permit, op_refused}, 2'h2);
        // Reset in mid-run clears the bus side and a held decision
        reset_n = 1'b0;
        @(negedge clk);
        reset_n = 1'b1;
        op_active = 1'b0;
        check({lad_oe, lad_out, op_permit, op_refused}, 7'h3c);
        check({wr_strobe, wr_data}, 9'h000);
        check(wr_addr, 32'h0);
        for (int i = 0; i < 16; i++)
        begin
            @(negedge clk);
            op_sector = i[3] ? LPCW_TOP_SECTOR : 4'h3;
            top_sector_guard_n = i[2];
            write_guard_n = i[1];
            write_lock = i[0] ? 16'h1 << op_sector : 16'h0;
            blk = (i[3] ? !i[2] : !i[1]) | i[0];
            op_start = 1'b1; op_active = 1'b1;
            @(negedge clk);
            op_start = 1'b0;
            check({op_permit, op_refused}, {!blk, blk});
            top_sector_guard_n = !i[2]; write_guard_n = !i[1]; write_lock = 16'h0;
            repeat (2) @(negedge clk);
            check({op_permit, op_refused}, {!blk, blk});
            op_active = 1'b0;
            repeat (2) @(negedge clk);
            check({op_permit, op_refused}, 2'h0);
        end
        stop_test();
    end
    initial
    begin
        #100000;
        errors++;
        stop_test();
    end
endmodule
